// file: logic/coulomb_pkg.sv
// How it works
// RL1: sync mode keeps written prescaler reset
// RL2: sync mode cleared clears prescaler reset
// RL3: prescaler reset self-clears outside sync mode
// RL4: instant result every 3.9 ms
// RL5: instant bytes and flag update together
// RL6: low byte read freezes instant result
// RL7: software reads instant bytes within period
// RL8: accumulate period 125 to 1000 ms
// RL9: period field 00..11 maps 125ms..1s
// RL10: accumulate bytes and flag update together
// RL11: byte0 read freezes accumulate until byte3
// RL12: software reads accumulate within period
// RL13: instant 13 bits, accumulate 18 bits
// RL14: results sign-extended to 16/32 bits
// RL15: threshold hit raises regular-current flag
// RL16: detection runs except power-down/off
// RL17: sampling mode: one conversion then off
// RL18: interval field 00..11 maps 250ms..2s
// RL19: sampling enable write aborts conversion
// RL20: halt in power-down, resume on wake
// RL21: power-off keeps converter disabled
// RL22: enable starts, disable terminates conversion
// RL23: software drops first four results
// RL24: software enables bandgap separately
// RL25: software subtracts stored zero offset
package coulomb_pkg;
   // clock rate
   localparam int unsigned CLK_MHZ = 100;
   // instant conversion period in microseconds
   localparam int unsigned INST_PERIOD_US = 3900;
   localparam int unsigned INST_CYC = INST_PERIOD_US * CLK_MHZ;
   // shortest accumulate period in milliseconds
   localparam int unsigned ACC_BASE_MS = 125;
   localparam int unsigned ACC_BASE_CYC = ACC_BASE_MS * 1000 * CLK_MHZ;
   // shortest sampling off time in milliseconds
   localparam int unsigned OFF_BASE_MS = 250;
   localparam int unsigned OFF_BASE_CYC = OFF_BASE_MS * 1000 * CLK_MHZ;
   // word indices of registers, byte address is four times
   localparam logic [3:0] IDX_TIMER = 4'h0;
   localparam logic [3:0] IDX_CSRA = 4'h1;
   localparam logic [3:0] IDX_CSRB = 4'h2;
   localparam logic [3:0] IDX_INST_LO = 4'h3;
   localparam logic [3:0] IDX_INST_HI = 4'h4;
   localparam logic [3:0] IDX_ACC0 = 4'h5;
   localparam logic [3:0] IDX_ACC3 = 4'h8;
   localparam logic [3:0] IDX_CHG_LVL = 4'h9;
   localparam logic [3:0] IDX_DIS_LVL = 4'hA;
   // field positions
   localparam int POS_TSM = 7;
   localparam int POS_PSR = 0;
   localparam int POS_EN = 7;
   localparam int POS_BUSY = 5;
   localparam int POS_AS = 3;
   localparam int POS_SI = 1;
   localparam int POS_SE = 0;
   localparam int POS_ACIE = 6;
   localparam int POS_RCIE = 5;
   localparam int POS_ICIE = 4;
   localparam int POS_ACIF = 2;
   localparam int POS_RCIF = 1;
   localparam int POS_ICIF = 0;
   // result widths
   localparam int INST_BITS = 13;
   localparam int ACC_BITS = 18;
   // reset values
   localparam logic [15:0] LEVEL_RESET = 16'h0000;
   // power modes seen by the block
   typedef enum logic [1:0] {
      PM_ACTIVE, PM_SAVE, PM_DOWN, PM_OFF
   } powerMode_type;
   // sequencer states
   typedef enum logic [1:0] {
      SEQ_IDLE, SEQ_CONVERT, SEQ_OFF
   } seqState_type;
endpackage

// file: logic/conv_seq_if.sv
// control and completion events between register side and sequencer
interface conv_seq_if;
   logic run;
   logic restart;
   logic sampling;
   logic [1:0] accSel;
   logic [1:0] offSel;
   logic instDone;
   logic accDone;
   modport ctrl(output run, restart, sampling, accSel, offSel, input instDone, accDone);
   modport timer(input run, restart, sampling, accSel, offSel, output instDone, accDone);
endinterface

// file: logic/conv_sequencer.sv
module conv_sequencer #(
   parameter int unsigned INST_CYC = coulomb_pkg::INST_CYC,
   parameter int unsigned ACC_BASE_CYC = coulomb_pkg::ACC_BASE_CYC,
   parameter int unsigned OFF_BASE_CYC = coulomb_pkg::OFF_BASE_CYC
) (
   input wire logic clk_sys,
   input wire logic reset,
   conv_seq_if.timer seq
);
   import coulomb_pkg::*;
   seqState_type state_q; // conversion phase
   logic [31:0] cnt_q; // instant or off counter
   logic [31:0] accCnt_q; // accumulate counter
   logic [31:0] accLimit; // selected accumulate length
   logic [31:0] offLimit; // selected off length
   logic [31:0] instLimit; // instant length

   // lengths: instant fixed, accumulate and off from the select fields
   always_comb begin
      instLimit = 32'(INST_CYC);
      // RL9 period encoding
      accLimit = 32'(ACC_BASE_CYC) << seq.accSel;
      // RL18 interval encoding
      offLimit = 32'(OFF_BASE_CYC) << seq.offSel;
   end

   // conversion sequencing
   always_ff @(posedge clk_sys) begin
      seq.instDone <= 1'b0;
      seq.accDone <= 1'b0;
      if (reset || !seq.run) begin
         // RL22 disable terminates conversion
         state_q <= SEQ_IDLE;
         cnt_q <= 32'h0000_0000;
         accCnt_q <= 32'h0000_0000;
      end else if (seq.restart || state_q == SEQ_IDLE) begin
         // RL19 abort and start fresh
         state_q <= SEQ_CONVERT;
         cnt_q <= 32'h0000_0000;
         accCnt_q <= 32'h0000_0000;
      end else begin
         unique case (state_q)
            SEQ_CONVERT: begin
               // RL4 fixed instant period
               if (cnt_q == instLimit - 32'h0000_0001) begin
                  seq.instDone <= 1'b1;
                  cnt_q <= 32'h0000_0000;
                  // RL17 go dark after one conversion
                  if (seq.sampling) begin
                     state_q <= SEQ_OFF;
                  end
               end else begin
                  cnt_q <= cnt_q + 32'h0000_0001;
               end
               // RL8 accumulate only in continuous mode
               if (seq.sampling) begin
                  accCnt_q <= 32'h0000_0000;
               end else if (accCnt_q >= accLimit - 32'h0000_0001) begin
                  seq.accDone <= 1'b1;
                  accCnt_q <= 32'h0000_0000;
               end else begin
                  accCnt_q <= accCnt_q + 32'h0000_0001;
               end
            end
            SEQ_OFF: begin
               // off interval then next sample
               if (cnt_q >= offLimit - 32'h0000_0001) begin
                  state_q <= SEQ_CONVERT;
                  cnt_q <= 32'h0000_0000;
               end else begin
                  cnt_q <= cnt_q + 32'h0000_0001;
               end
            end
            default: begin
               state_q <= SEQ_IDLE;
            end
         endcase
      end
   end
endmodule // conv_sequencer

// file: logic/coulomb_counter_readout_control.sv
// Local design decisions: the Avalon-MM slave port and the placing of the registers.
module coulomb_counter_readout_control #(
   parameter int unsigned INST_CYC = coulomb_pkg::INST_CYC,
   parameter int unsigned ACC_BASE_CYC = coulomb_pkg::ACC_BASE_CYC,
   parameter int unsigned OFF_BASE_CYC = coulomb_pkg::OFF_BASE_CYC
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [3:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic [coulomb_pkg::INST_BITS-1:0] instCode,
   input wire logic [coulomb_pkg::ACC_BITS-1:0] accumCode,
   input wire coulomb_pkg::powerMode_type powerMode,
   output logic converterOn,
   output logic prescalerReset,
   output logic instIrq,
   output logic accumIrq,
   output logic regularIrq
);
   import coulomb_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // declarations
   conv_seq_if seq();
   logic waitReq_q; // bus answer pending when high
   logic [7:0] rdData_q; // read answer byte
   logic rdCap; // read answer latched this edge
   logic instLoad; // instant result accepted this edge
   logic accLoad; // accumulate result accepted this edge
   logic wrAcc; // write taken this edge
   logic wrLane; // write with low lane enabled
   logic timerSyncMode_q; // hold prescaler reset
   logic sharedPrescalerReset_q; // prescaler reset bit
   logic converterEnable_q; // converter enable
   logic samplingEnable_q; // sampling mode
   logic [1:0] accumPeriodSelect_q; // accumulate period
   logic [1:0] samplingIntervalSelect_q; // off interval
   logic [2:0] intEnable_q; // acc, regular, instant enables
   logic [2:0] intFlag_q; // acc, regular, instant flags
   logic [15:0] instResult_q; // instant result
   logic [31:0] accResult_q; // accumulate result
   logic instLock_q; // instant bytes frozen
   logic accLock_q; // accumulate bytes frozen
   logic [15:0] chargeLevel_q; // positive threshold
   logic [15:0] dischargeLevel_q; // negative threshold
   logic [15:0] instExt; // extended instant code
   logic [31:0] accExt; // extended accumulate code
   logic [15:0] instMag; // magnitude of instant code
   logic regularHit; // threshold reached
   logic runNow; // converter allowed to run
   logic [2:0] flagSet; // hardware set events
   logic [2:0] flagClr; // software clear requests

   ////////////////////////////////////////////////////////////////////
   // bus slave: one wait cycle, then answer
   assign rdCap = read && waitReq_q;
   assign wrAcc = write && !waitReq_q;
   assign wrLane = wrAcc && byteenable[0];
   assign waitrequest = waitReq_q;
   assign readdata = {24'h00_0000, rdData_q};

   // wait request: low for exactly one edge per request
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         waitReq_q <= 1'b1;
      end else begin
         waitReq_q <= !((read || write) && waitReq_q);
      end
   end

   // read answer built while the request waits
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         rdData_q <= 8'h00;
      end else if (rdCap) begin
         unique case (address)
            IDX_TIMER: rdData_q <= 8'({timerSyncMode_q, 6'h00, sharedPrescalerReset_q});
            IDX_CSRA: rdData_q <= {converterEnable_q, 2'b00, accumPeriodSelect_q,
                                   samplingIntervalSelect_q, samplingEnable_q};
            IDX_CSRB: rdData_q <= {1'b0, intEnable_q, 1'b0, intFlag_q};
            IDX_INST_LO: rdData_q <= instResult_q[7:0];
            IDX_INST_HI: rdData_q <= instResult_q[15:8];
            4'h5: rdData_q <= accResult_q[7:0];
            4'h6: rdData_q <= accResult_q[15:8];
            4'h7: rdData_q <= accResult_q[23:16];
            IDX_ACC3: rdData_q <= accResult_q[31:24];
            IDX_CHG_LVL: rdData_q <= chargeLevel_q[7:0];
            IDX_DIS_LVL: rdData_q <= dischargeLevel_q[7:0];
            default: rdData_q <= 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // timer prescaler control
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         timerSyncMode_q <= 1'b0;
         sharedPrescalerReset_q <= 1'b0;
      end else if (wrLane && address == IDX_TIMER) begin
         timerSyncMode_q <= writedata[POS_TSM];
         // RL1 written value kept
         sharedPrescalerReset_q <= writedata[POS_PSR];
      end else if (!timerSyncMode_q) begin
         // RL2 RL3 hardware clears outside sync mode
         sharedPrescalerReset_q <= 1'b0;
      end
   end
   assign prescalerReset = sharedPrescalerReset_q;

   ////////////////////////////////////////////////////////////////////
   // converter control and thresholds
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         converterEnable_q <= 1'b0;
         samplingEnable_q <= 1'b0;
         accumPeriodSelect_q <= 2'b00;
         samplingIntervalSelect_q <= 2'b00;
         intEnable_q <= 3'b000;
         chargeLevel_q <= LEVEL_RESET;
         dischargeLevel_q <= LEVEL_RESET;
      end else if (wrLane) begin
         if (address == IDX_CSRA) begin
            converterEnable_q <= writedata[POS_EN];
            accumPeriodSelect_q <= writedata[POS_AS +: 2];
            samplingIntervalSelect_q <= writedata[POS_SI +: 2];
            samplingEnable_q <= writedata[POS_SE];
         end
         if (address == IDX_CSRB) begin
            intEnable_q <= {writedata[POS_ACIE], writedata[POS_RCIE], writedata[POS_ICIE]};
         end
         if (address == IDX_CHG_LVL) begin
            chargeLevel_q <= {8'h00, writedata[7:0]};
         end
         if (address == IDX_DIS_LVL) begin
            dischargeLevel_q <= {8'h00, writedata[7:0]};
         end
      end
   end

   // run gating by power mode
   // RL16 RL20 RL21 halted in power-down and power-off
   assign runNow = converterEnable_q && powerMode != PM_DOWN && powerMode != PM_OFF;

   // run level and abort pulse toward the sequencer
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         seq.run <= 1'b0;
         seq.restart <= 1'b0;
         converterOn <= 1'b0;
      end else begin
         // RL22 enable starts measurement, continuous or sampling as the sampling enable selects
         seq.run <= runNow;
         converterOn <= runNow;
         // RL19 writing one aborts ongoing conversion
         seq.restart <= wrLane && address == IDX_CSRA && writedata[POS_SE];
      end
   end
   assign seq.sampling = samplingEnable_q;
   assign seq.accSel = accumPeriodSelect_q;
   assign seq.offSel = samplingIntervalSelect_q;

   conv_sequencer #(
      .INST_CYC(INST_CYC),
      .ACC_BASE_CYC(ACC_BASE_CYC),
      .OFF_BASE_CYC(OFF_BASE_CYC)
   ) u_seq (
      .clk_sys(clk_sys),
      .reset(reset),
      .seq(seq)
   );

   ////////////////////////////////////////////////////////////////////
   // result capture with read locks
   // RL13 RL14 sign extension of codes
   assign instExt = {{(16-INST_BITS){instCode[INST_BITS-1]}}, instCode};
   assign accExt = {{(32-ACC_BITS){accumCode[ACC_BITS-1]}}, accumCode};

   // lock starts at the edge that latches the low byte, so no load slips in
   assign instLoad = seq.instDone && !instLock_q && !(rdCap && address == IDX_INST_LO);
   assign accLoad = seq.accDone && !accLock_q && !(rdCap && address == IDX_ACC0);

   // instant result and its lock
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         instResult_q <= 16'h0000;
         instLock_q <= 1'b0;
      end else begin
         // RL5 load on completion unless frozen
         if (instLoad) begin
            instResult_q <= instExt;
         end
         // RL6 freeze from low byte until high byte
         if (rdCap && address == IDX_INST_LO) begin
            instLock_q <= 1'b1;
         end else if (rdCap && address == IDX_INST_HI) begin
            instLock_q <= 1'b0;
         end
      end
   end

   // accumulate result and its lock
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         accResult_q <= 32'h0000_0000;
         accLock_q <= 1'b0;
      end else begin
         // RL10 all four bytes at once
         if (accLoad) begin
            accResult_q <= accExt;
         end
         // RL11 freeze from byte0 until byte3
         if (rdCap && address == IDX_ACC0) begin
            accLock_q <= 1'b1;
         end else if (rdCap && address == IDX_ACC3) begin
            accLock_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // flags: set wins over write-one clear
   assign instMag = instExt[15] ? 16'(-instExt) : instExt;
   // RL15 compare against charge or discharge level
   assign regularHit = instExt[15] ? (instMag >= dischargeLevel_q) : (instMag >= chargeLevel_q);
   assign flagSet = {accLoad, seq.instDone && regularHit, instLoad};
   assign flagClr = (wrLane && address == IDX_CSRB) ?
                    {writedata[POS_ACIF], writedata[POS_RCIF], writedata[POS_ICIF]} : 3'b000;

   // sticky flags
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         intFlag_q <= 3'b000;
      end else begin
         intFlag_q <= flagSet | (intFlag_q & ~flagClr);
      end
   end

   // request lines, flag gated by enable
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         instIrq <= 1'b0;
         regularIrq <= 1'b0;
         accumIrq <= 1'b0;
      end else begin
         instIrq <= intEnable_q[0] && (flagSet[0] || (intFlag_q[0] && !flagClr[0]));
         regularIrq <= intEnable_q[1] && (flagSet[1] || (intFlag_q[1] && !flagClr[1]));
         accumIrq <= intEnable_q[2] && (flagSet[2] || (intFlag_q[2] && !flagClr[2]));
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   property p_psr_hold;
      timerSyncMode_q && sharedPrescalerReset_q && !wrLane |=> sharedPrescalerReset_q;
   endproperty
   a_psr_hold: assert property (p_psr_hold) else $error("prescaler reset lost in sync"); // RL1

   property p_tsm_clear;
      $fell(timerSyncMode_q) ##1 !wrLane |-> !sharedPrescalerReset_q;
   endproperty
   a_tsm_clear: assert property (p_tsm_clear) else $error("prescaler reset not cleared"); // RL2

   property p_psr_self;
      sharedPrescalerReset_q && !timerSyncMode_q && !wrLane |=> !sharedPrescalerReset_q;
   endproperty
   a_psr_self: assert property (p_psr_self) else $error("prescaler reset stuck"); // RL3

   property p_inst_load;
      instLoad |=> instResult_q == $past(instExt) && intFlag_q[0];
   endproperty
   a_inst_load: assert property (p_inst_load) else $error("instant result not loaded"); // RL5

   property p_inst_freeze;
      instLock_q |=> $stable(instResult_q);
   endproperty
   a_inst_freeze: assert property (p_inst_freeze) else $error("instant result moved"); // RL6

   property p_acc_load;
      accLoad |=> accResult_q == $past(accExt) && intFlag_q[2];
   endproperty
   a_acc_load: assert property (p_acc_load) else $error("accumulate result not loaded"); // RL10

   property p_acc_freeze;
      accLock_q |=> $stable(accResult_q);
   endproperty
   a_acc_freeze: assert property (p_acc_freeze) else $error("accumulate result moved"); // RL11

   property p_regular;
      seq.instDone && regularHit |=> intFlag_q[1];
   endproperty
   a_regular: assert property (p_regular) else $error("regular flag missed"); // RL15

   property p_power_off;
      powerMode == PM_OFF |-> ##2 !seq.instDone;
   endproperty
   a_power_off: assert property (p_power_off) else $error("converting in power-off"); // RL21

   property p_answer;
      (read || write) && waitReq_q |=> !waitReq_q;
   endproperty
   a_answer: assert property (p_answer) else $error("bus answer late");

   property p_disable;
      !converterEnable_q |=> !converterOn;
   endproperty
   a_disable: assert property (p_disable) else $error("converter on while disabled"); // RL22

   c_inst_lost: cover property (instLock_q && seq.instDone);
   c_acc_done: cover property (seq.accDone ##1 accumIrq);
   c_regular: cover property (seq.instDone && regularHit && seq.sampling);
endmodule // coulomb_counter_readout_control

// file: bench/charge_sense_model.sv
// front end model: sense resistor seen through the modulator
module charge_sense_model (
   input wire logic clk_sys,
   input wire logic converterOn,
   input wire logic [coulomb_pkg::INST_BITS-1:0] instSet,
   input wire logic [coulomb_pkg::ACC_BITS-1:0] accSet,
   output logic [coulomb_pkg::INST_BITS-1:0] instCode,
   output logic [coulomb_pkg::ACC_BITS-1:0] accumCode
);
   timeunit 1ns;
   timeprecision 1ns;
   import coulomb_pkg::*;
   logic flip_q = 1'b0; // toggles so a dead front end never looks stable
   ////////////////////////////////////////////////////////////////////////
   // toggle source for the scrambled idle pattern
   always @(posedge clk_sys) begin
      flip_q <= ~flip_q;
   end
   ////////////////////////////////////////////////////////////////////////
   // signed code widths
   // codes are only meaningful while the converter runs
   always_comb begin
      if (converterOn) begin
         instCode = instSet;
         accumCode = accSet;
      end else begin
         instCode = {INST_BITS{flip_q}} ^ ~instSet;
         accumCode = {ACC_BITS{flip_q}} ^ ~accSet;
      end
   end
endmodule // charge_sense_model

// file: bench/tb_coulomb_counter_readout_control.sv
module tb_coulomb_counter_readout_control;
   timeunit 1ns;
   timeprecision 1ns;
   import coulomb_pkg::*;
   localparam int IC = 20; // shortened instant period
   localparam int AB = 40; // shortened accumulate base period
   localparam int OB = 30; // shortened sampling off base
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic [3:0] address = 4'h0;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0000_0000;
   logic [3:0] byteenable = 4'hF;
   logic [31:0] readdata;
   logic waitrequest;
   logic [INST_BITS-1:0] instCode;
   logic [INST_BITS-1:0] instSet = 13'h1FFB; // minus five
   logic [ACC_BITS-1:0] accumCode;
   logic [ACC_BITS-1:0] accSet = 18'h3_FFFD; // minus three
   powerMode_type powerMode = PM_ACTIVE;
   logic converterOn;
   logic prescalerReset;
   logic instIrq;
   logic accumIrq;
   logic regularIrq;
   int psrHigh = 0; // cycles the prescaler reset stood high
   wire [2:0] irqs = {accumIrq, regularIrq, instIrq};
   int n_errors = 0;
   int checks_done = 0;
   int cycles = 0;
   int n;
   coulomb_counter_readout_control #(.INST_CYC(IC), .ACC_BASE_CYC(AB), .OFF_BASE_CYC(OB)) dut_u (
      .clk_sys(clk_sys), .reset(reset), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .instCode(instCode), .accumCode(accumCode),
      .powerMode(powerMode), .converterOn(converterOn), .prescalerReset(prescalerReset),
      .instIrq(instIrq), .accumIrq(accumIrq), .regularIrq(regularIrq));
   charge_sense_model model_u (.clk_sys(clk_sys), .converterOn(converterOn), .instSet(instSet),
      .accSet(accSet), .instCode(instCode), .accumCode(accumCode));
   ////////////////////////////////////////////////////////////////////////
   // clock, cycle count and hang guard
   initial begin
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (prescalerReset === 1'b1) psrHigh <= psrHigh + 1;
      if (cycles == 8000) begin
         n_errors++;
         wrap_up();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // verdict
   task automatic wrap_up();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   // avalon master: request held until waitrequest sampled low
   task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
                      input logic [3:0] be, output logic [7:0] q);
      int t;
      @(posedge clk_sys);
      address <= a;
      read <= ~wr;
      write <= wr;
      writedata <= {24'h00_0000, d};
      byteenable <= be;
      t = 0;
      do begin
         @(posedge clk_sys);
         t++;
      end while (waitrequest !== 1'b0 && t < 50);
      chk("bus answer", 32'h0000_0001, 32'(t < 50));
      q = readdata[7:0];
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b1, a, d, 4'hF, q);
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e, input string nm);
      logic [7:0] q;
      bus(1'b0, a, 8'h00, 4'hF, q);
      chk(nm, 32'(e), 32'(q));
      chk("readdata upper", 32'h0000_0000, 32'(readdata[31:8]));
   endtask
   // clear one flag, then wait for its interrupt to rise again
   task automatic rise(input int b, input int lim, output int n);
      logic prev;
      wr(IDX_CSRB, 8'h70 | 8'(1 << b));
      prev = 1'b1;
      n = 0;
      while (n < lim && !(prev === 1'b0 && irqs[b] === 1'b1)) begin
         prev = irqs[b];
         @(posedge clk_sys);
         n++;
      end
   endtask
   // distance between two rising edges of one interrupt
   task automatic period(input int b, input int e);
      int t0;
      int k;
      rise(b, 2 * e + 8, k);
      t0 = cycles;
      rise(b, 2 * e + 8, k);
      chk("period", 32'(e), 32'(cycles - t0));
   endtask
   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      repeat (8) @(posedge clk_sys);
      reset <= 1'b0;
      for (int i = 0; i < 16; i++) begin
         rd(i[3:0], 8'h00, "reset value");
      end
      wr(IDX_TIMER, 8'h81);
      rd(IDX_TIMER, 8'h81, "sync hold");
      chk("prescalerReset held", 32'h0000_0001, 32'(prescalerReset));
      wr(IDX_TIMER, 8'h00);
      rd(IDX_TIMER, 8'h00, "sync off");
      chk("prescalerReset released", 32'h0000_0000, 32'(prescalerReset));
      n = psrHigh;
      wr(IDX_TIMER, 8'h01);
      rd(IDX_TIMER, 8'h00, "self clear");
      chk("prescalerReset pulse", 32'h0000_0001, 32'(psrHigh - n));
      bus(1'b1, IDX_CHG_LVL, 8'h55, 4'hE, n[7:0]);
      rd(IDX_CHG_LVL, 8'h00, "masked write");
      wr(IDX_CSRB, 8'h70);
      wr(IDX_CSRA, 8'h80);
      repeat (2) @(posedge clk_sys);
      chk("converterOn", 32'h0000_0001, 32'(converterOn));
      repeat (4) rise(0, 2 * IC + 8, n);
      period(0, IC);
      rise(0, 2 * IC + 8, n);
      rd(IDX_INST_LO, 8'hFB, "inst low");
      instSet <= 13'h0007;
      wr(IDX_CSRB, 8'h71);
      repeat (3 * IC) @(posedge clk_sys);
      chk("instIrq frozen", 32'h0000_0000, 32'(instIrq));
      rd(IDX_INST_HI, 8'hFF, "inst high held");
      rise(0, 2 * IC + 8, n);
      rd(IDX_INST_LO, 8'h07, "inst low new");
      rd(IDX_INST_HI, 8'h00, "inst high new");
      wr(IDX_CHG_LVL, 8'h08);
      wr(IDX_DIS_LVL, 8'h08);
      repeat (2 * IC) @(posedge clk_sys);
      wr(IDX_CSRB, 8'h72);
      repeat (2 * IC) @(posedge clk_sys);
      chk("regular below", 32'h0000_0000, 32'(regularIrq));
      instSet <= 13'h1FF7;
      rise(1, 2 * IC + 8, n);
      chk("regular discharge", 32'h0000_0001, 32'(regularIrq));
      powerMode <= PM_SAVE;
      rise(1, 2 * IC + 8, n);
      chk("regular in save", 32'h0000_0001, 32'(regularIrq));
      powerMode <= PM_DOWN;
      repeat (4) @(posedge clk_sys);
      rise(0, 3 * IC, n);
      chk("instIrq halted", 32'h0000_0000, 32'(instIrq));
      chk("converterOn down", 32'h0000_0000, 32'(converterOn));
      powerMode <= PM_ACTIVE;
      rise(0, 2 * IC + 8, n);
      chk("instIrq resumed", 32'h0000_0001, 32'(instIrq));
      powerMode <= PM_OFF;
      repeat (3) @(posedge clk_sys);
      chk("converterOn off", 32'h0000_0000, 32'(converterOn));
      powerMode <= PM_ACTIVE;
      for (int s = 0; s < 4; s++) begin
         wr(IDX_CSRA, 8'h80 | 8'(s << 3));
         period(2, AB << s);
      end
      wr(IDX_CSRA, 8'h80);
      rise(2, 2 * AB + 8, n);
      rd(IDX_ACC0, 8'hFD, "acc byte0");
      accSet <= 18'h0_0010;
      repeat (3 * AB) @(posedge clk_sys);
      rd(IDX_ACC0 + 4'h1, 8'hFF, "acc byte1 held");
      rd(IDX_ACC0 + 4'h2, 8'hFF, "acc byte2 held");
      rd(IDX_ACC3, 8'hFF, "acc byte3 held");
      rise(2, 2 * AB + 8, n);
      rd(IDX_ACC0, 8'h10, "acc byte0 new");
      rd(IDX_ACC3, 8'h00, "acc byte3 new");
      for (int s = 0; s < 4; s++) begin
         wr(IDX_CSRA, 8'h81 | 8'(s << 1));
         period(0, IC + (OB << s));
      end
      wr(IDX_CSRA, 8'h00);
      repeat (2) @(posedge clk_sys);
      chk("converterOn cleared", 32'h0000_0000, 32'(converterOn));
      rise(0, 3 * IC, n);
      chk("no conversion", 32'h0000_0000, 32'(instIrq));
      wrap_up();
   end
endmodule // tb_coulomb_counter_readout_control
